// File: bench/jtl_link_cfg_bench.sv
// testbench for the transmit link config bank
// assumes the receiver model drives sync and sysref
`timescale 1ns/100ps
`default_nettype none
module jtl_link_cfg_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [13:0] adr = 14'h0000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wait_o, sync_n, sysref, edge_o, ilas;
   logic [4:0] phase;
   logic [7:0] octet;
   jtl_pkg::jtl_cfg_t cfg;
   jtl_pkg::jtl_mode_t mode;
   int n_errors = 0;
   int n_checks = 0;
   logic [11:0] idx_t [9] = '{12'h574, 12'h578, 12'h580, 12'h581,
      12'h583, 12'h585, 12'h58b, 12'h58c, 12'h582};
   logic [7:0] rst_t [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
      8'h81, 8'h01, 8'h00};
   logic [7:0] one_t [9] = '{8'hf7, 8'h1f, 8'hff, 8'h0f, 8'h1f, 8'h1f,
      8'h81, 8'h01, 8'h00};
   logic [7:0] zer_t [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h01, 8'h01, 8'h00};

   always #2.5 clk_i = ~clk_i;

   jtl_link_cfg u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_o), .sync_n_i(sync_n), .sysref_i(sysref),
      .cfg_o(cfg), .lmfc_phase_o(phase), .lmfc_edge_o(edge_o),
      .ilas_start_o(ilas), .link_mode_o(mode), .test_octet_o(octet));

   jtl_rx_model u_rx (.clk_i(clk_i), .sync_n_o(sync_n),
      .sysref_o(sysref));

   task automatic test_done();
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one transfer; data taken at the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [11:0] idx,
      input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (wait_o !== 1'b0 && n < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 50) chk("waitrequest", 32'h0, {31'h0, wait_o});
      @(posedge clk_i);
   endtask

   task automatic fill_check(input logic [7:0] d, input logic [7:0] e [9]);
      logic [31:0] q;
      for (int i = 0; i < 9; i++) bus(1'b1, idx_t[i], d, q);
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, idx_t[i], 8'h00, q);
         chk("reg", {24'h0, e[i]}, q);
      end
   endtask

   task automatic t_regs();
      logic [31:0] q;
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, idx_t[i], 8'h00, q);
         chk("reset", {24'h0, rst_t[i]}, q);
      end
      fill_check(8'hff, one_t);
      chk("dev_id", 32'hff, {24'h0, cfg.dev_id});
      chk("bank_id", 32'h0f, {28'h0, cfg.bank_id});
      chk("lane1_id", 32'h1f, {27'h0, cfg.lane1_id});
      fill_check(8'h00, zer_t);
      chk("scr_en", 32'h0, {31'h0, cfg.scr_en});
   endtask

   task automatic t_mode();
      logic [31:0] q;
      logic [2:0] e;
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 12'h574, c[7:0], q);
         repeat (3) @(posedge clk_i);
         // reserved codes fall back to normal mode
         e = (c == 2 || c == 3 || c == 7) ? 3'h0 : c[2:0];
         chk("mode", {29'h0, e}, {29'h0, mode});
         chk("octet", (c == 1) ? 32'hb5 : 32'h0, {24'h0, octet});
      end
   endtask

   task automatic t_lmfc();
      logic [31:0] q;
      bus(1'b1, 12'h578, 8'h13, q);
      u_rx.pulse_sysref();
      @(posedge clk_i);
      chk("phase", 32'h13, {27'h0, phase});
   endtask

   task automatic t_ilas();
      logic [31:0] q;
      int k, n;
      for (int c = 10; c < 16; c++) begin
         bus(1'b1, 12'h574, {c[3:0], 4'h0}, q);
         // release well away from an lmfc edge
         while (phase !== 5'h05) @(posedge clk_i);
         u_rx.resync();
         k = 0;
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
            if (edge_o === 1'b1) k++;
         end while (ilas !== 1'b1 && n < 700);
         chk("ilas_edges", c + 1, k);
      end
   endtask

   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      test_done();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_regs();
      t_mode();
      t_lmfc();
      t_ilas();
      test_done();
   end
endmodule
`default_nettype wire

// File: bench/jtl_rx_model.sv
// receiver-side model: drives the sync request and sysref lines
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module jtl_rx_model (
   input wire logic clk_i,
   output logic sync_n_o,
   output logic sysref_o
);
   initial begin
      sync_n_o = 1'b0;
      sysref_o = 1'b0;
   end
   // request, then release
   // a long low also checks that a request aborts and re-arms
   task automatic resync();
      sync_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sync_n_o <= 1'b1;
   endtask
   task automatic pulse_sysref();
      sysref_o <= 1'b1;
      @(posedge clk_i);
      sysref_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: logic/jtl_link_cfg.sv
// register bank and alignment timing for the transmit link
// assumes an avalon-mm master that holds each request until waitrequest low
`timescale 1ns/100ps
`default_nettype none
module jtl_link_cfg (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [13:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic sync_n_i,
   input wire logic sysref_i,
   output var jtl_pkg::jtl_cfg_t cfg_o,
   output logic [4:0] lmfc_phase_o,
   output logic lmfc_edge_o,
   output logic ilas_start_o,
   output var jtl_pkg::jtl_mode_t link_mode_o,
   output logic [7:0] test_octet_o
);
   logic [11:0] idx;
   logic acc_go;
   logic wr_go;
   logic [31:0] next_rdata;
   logic [7:0] wd;
   jtl_pkg::jtl_state_t state;
   logic [3:0] edge_cnt;
   logic sync_q;

   assign idx = avs_address_i[13:2];
   assign wd = avs_writedata_i[7:0];
   // first cycle of a request is accepted, the next one completes it
   assign acc_go = (avs_read_i | avs_write_i) & avs_waitrequest_o;
   assign wr_go = avs_write_i & ~avs_waitrequest_o;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= ~acc_go;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_o.dev_id <= jtl_pkg::RST_DEV_ID;
         cfg_o.bank_id <= jtl_pkg::RST_BANK_ID;
         cfg_o.lane0_id <= jtl_pkg::RST_LANE0_ID;
         cfg_o.lane1_id <= jtl_pkg::RST_LANE1_ID;
         cfg_o.scr_en <= jtl_pkg::RST_SCR_EN;
         cfg_o.lmfc_off <= jtl_pkg::RST_LMFC_OFF;
         cfg_o.ilas_dly <= jtl_pkg::RST_ILAS_DLY;
         cfg_o.test_sel <= jtl_pkg::RST_TEST_SEL;
      end else if (wr_go) begin
         unique case (idx)
            jtl_pkg::IDX_ALIGN_TEST: begin
               cfg_o.ilas_dly <= wd[jtl_pkg::DLY_LSB +: 4];
               cfg_o.test_sel <= wd[2:0];
            end
            jtl_pkg::IDX_LMFC_OFF: cfg_o.lmfc_off <= wd[4:0];
            jtl_pkg::IDX_DEV_ID: cfg_o.dev_id <= wd;
            jtl_pkg::IDX_BANK_ID: cfg_o.bank_id <= wd[3:0];
            jtl_pkg::IDX_LANE0_ID: cfg_o.lane0_id <= wd[4:0];
            jtl_pkg::IDX_LANE1_ID: cfg_o.lane1_id <= wd[4:0];
            jtl_pkg::IDX_SCR_LANES: cfg_o.scr_en <= wd[jtl_pkg::SCR_BIT];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (idx)
         jtl_pkg::IDX_ALIGN_TEST:
            next_rdata[7:0] = {cfg_o.ilas_dly, 1'b0, cfg_o.test_sel};
         jtl_pkg::IDX_LMFC_OFF: next_rdata[7:0] = {3'h0, cfg_o.lmfc_off};
         jtl_pkg::IDX_DEV_ID: next_rdata[7:0] = cfg_o.dev_id;
         jtl_pkg::IDX_BANK_ID: next_rdata[7:0] = {4'h0, cfg_o.bank_id};
         jtl_pkg::IDX_LANE0_ID: next_rdata[7:0] = {3'h0, cfg_o.lane0_id};
         jtl_pkg::IDX_LANE1_ID: next_rdata[7:0] = {3'h0, cfg_o.lane1_id};
         jtl_pkg::IDX_SCR_LANES:
            next_rdata[7:0] = {cfg_o.scr_en, 2'h0, jtl_pkg::LANE_COUNT};
         jtl_pkg::IDX_OCTETS: next_rdata[7:0] = jtl_pkg::OCTETS_M1;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (acc_go & avs_read_i) begin
         avs_readdata_o <= next_rdata;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lmfc_phase_o <= 5'h00;
         lmfc_edge_o <= 1'b0;
      end else if (sysref_i) begin
         lmfc_phase_o <= cfg_o.lmfc_off;
         lmfc_edge_o <= (cfg_o.lmfc_off == 5'h00);
      end else begin
         lmfc_phase_o <= lmfc_phase_o + 5'h01;
         lmfc_edge_o <= (lmfc_phase_o == jtl_pkg::LMFC_LAST);
      end
   end

   // sync idles high; reset to that level so reset is no false release
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_q <= 1'b1;
      end else begin
         sync_q <= sync_n_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= jtl_pkg::JTL_IDLE;
         edge_cnt <= 4'h0;
         ilas_start_o <= 1'b0;
      end else begin
         ilas_start_o <= 1'b0;
         if (!sync_n_i) begin
            state <= jtl_pkg::JTL_IDLE;
         end else begin
            unique case (state)
               jtl_pkg::JTL_IDLE: begin
                  if (!sync_q) begin
                     state <= jtl_pkg::JTL_WAIT;
                     edge_cnt <= 4'h0;
                  end
               end
               jtl_pkg::JTL_WAIT: begin
                  if (lmfc_edge_o) begin
                     edge_cnt <= edge_cnt + 4'h1;
                     if (edge_cnt == cfg_o.ilas_dly) begin
                        ilas_start_o <= 1'b1;
                        state <= jtl_pkg::JTL_RUN;
                     end
                  end
               end
               jtl_pkg::JTL_RUN: state <= jtl_pkg::JTL_RUN;
               default: state <= jtl_pkg::JTL_IDLE;
            endcase
         end
      end
   end

   // test selector decode
   // reserved codes fall back to normal so the lanes never carry junk
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_mode_o <= jtl_pkg::JTL_NORMAL;
         test_octet_o <= 8'h00;
      end else begin
         test_octet_o <= 8'h00;
         unique case (cfg_o.test_sel)
            3'b001: begin
               link_mode_o <= jtl_pkg::JTL_D21_5;
               test_octet_o <= jtl_pkg::D21_5_OCTET;
            end
            3'b100: link_mode_o <= jtl_pkg::JTL_RPAT;
            3'b101: link_mode_o <= jtl_pkg::JTL_JSPAT;
            3'b110: link_mode_o <= jtl_pkg::JTL_JTSPAT;
            default: link_mode_o <= jtl_pkg::JTL_NORMAL;
         endcase
      end
   end

   property p_ilas_start;
      @(posedge clk_i) disable iff (!rst_n_i)
      (sync_n_i && state == jtl_pkg::JTL_WAIT && lmfc_edge_o &&
       edge_cnt == cfg_o.ilas_dly) |=> ilas_start_o;
   endproperty
   a_ilas_start: assert property (p_ilas_start)
      else $error("alignment start missed its lmfc edge");

   property p_ilas_cause;
      @(posedge clk_i) disable iff (!rst_n_i)
      ilas_start_o |-> $past(lmfc_edge_o) && $past(edge_cnt) ==
         $past(cfg_o.ilas_dly) && sync_q;
   endproperty
   a_ilas_cause: assert property (p_ilas_cause)
      else $error("alignment start without matching edge count");

   property p_d21;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel == 3'b001) |=> (test_octet_o == 8'hb5) &&
         (link_mode_o == jtl_pkg::JTL_D21_5);
   endproperty
   a_d21: assert property (p_d21)
      else $error("d21.5 test octet not sent");

   property p_normal;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel == 3'b000) [*2] |-> link_mode_o == jtl_pkg::JTL_NORMAL;
   endproperty
   a_normal: assert property (p_normal)
      else $error("normal mode not selected");

   property p_patterns;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel == 3'b100) |=> link_mode_o == jtl_pkg::JTL_RPAT;
   endproperty
   a_patterns: assert property (p_patterns)
      else $error("rpat not selected at code 100");

   property p_sysref;
      @(posedge clk_i) disable iff (!rst_n_i)
      sysref_i |=> lmfc_phase_o == $past(cfg_o.lmfc_off);
   endproperty
   a_sysref: assert property (p_sysref)
      else $error("lmfc phase not loaded with offset");

   property p_dev_id;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_go && idx == jtl_pkg::IDX_DEV_ID) |=>
         cfg_o.dev_id == $past(avs_writedata_i[7:0]);
   endproperty
   a_dev_id: assert property (p_dev_id)
      else $error("device id write lost");

   property p_scr;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_go && idx == jtl_pkg::IDX_SCR_LANES) |=>
         cfg_o.scr_en == $past(avs_writedata_i[7]);
   endproperty
   a_scr: assert property (p_scr)
      else $error("scrambler enable write lost");

   property p_ro_read;
      @(posedge clk_i) disable iff (!rst_n_i)
      (acc_go && avs_read_i && idx == jtl_pkg::IDX_OCTETS) |=>
         avs_readdata_o == 32'h0000_0001 && !avs_waitrequest_o;
   endproperty
   a_ro_read: assert property (p_ro_read)
      else $error("octets per frame reads wrong");

   property p_bank_rsv;
      @(posedge clk_i) disable iff (!rst_n_i)
      (acc_go && avs_read_i && idx == jtl_pkg::IDX_BANK_ID) |=>
         avs_readdata_o[31:4] == 28'h0000000;
   endproperty
   a_bank_rsv: assert property (p_bank_rsv)
      else $error("reserved bank id bits read nonzero");

   property p_jspat;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel == 3'b101) |=> link_mode_o == jtl_pkg::JTL_JSPAT;
   endproperty
   a_jspat: assert property (p_jspat)
      else $error("jspat not selected at code 101");

   property p_jtspat;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel == 3'b110) |=> link_mode_o == jtl_pkg::JTL_JTSPAT;
   endproperty
   a_jtspat: assert property (p_jtspat)
      else $error("jtspat not selected at code 110");

   property p_reserved;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel == 3'b010 || cfg_o.test_sel == 3'b011 ||
       cfg_o.test_sel == 3'b111) |=> link_mode_o == jtl_pkg::JTL_NORMAL;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved test code did not fall back to normal");

   property p_octet_idle;
      @(posedge clk_i) disable iff (!rst_n_i)
      (cfg_o.test_sel != 3'b001) |=> test_octet_o == 8'h00;
   endproperty
   a_octet_idle: assert property (p_octet_idle)
      else $error("test octet sent outside d21.5 mode");

   property p_lmfc_count;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!$past(sysref_i) && $past(rst_n_i)) |->
         lmfc_phase_o == $past(lmfc_phase_o) + 5'h01;
   endproperty
   a_lmfc_count: assert property (p_lmfc_count)
      else $error("lmfc phase did not advance by one");

   property p_lmfc_edge;
      @(posedge clk_i) disable iff (!rst_n_i)
      lmfc_edge_o |-> lmfc_phase_o == 5'h00;
   endproperty
   a_lmfc_edge: assert property (p_lmfc_edge)
      else $error("lmfc edge away from phase zero");

   property p_bank_id;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_go && idx == jtl_pkg::IDX_BANK_ID) |=>
         cfg_o.bank_id == $past(avs_writedata_i[3:0]);
   endproperty
   a_bank_id: assert property (p_bank_id)
      else $error("bank id write lost");

   property p_lane0_id;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_go && idx == jtl_pkg::IDX_LANE0_ID) |=>
         cfg_o.lane0_id == $past(avs_writedata_i[4:0]);
   endproperty
   a_lane0_id: assert property (p_lane0_id)
      else $error("lane 0 id write lost");

   property p_lane1_id;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wr_go && idx == jtl_pkg::IDX_LANE1_ID) |=>
         cfg_o.lane1_id == $past(avs_writedata_i[4:0]);
   endproperty
   a_lane1_id: assert property (p_lane1_id)
      else $error("lane 1 id write lost");

   property p_lanes_ro;
      @(posedge clk_i) disable iff (!rst_n_i)
      (acc_go && avs_read_i && idx == jtl_pkg::IDX_SCR_LANES) |=>
         avs_readdata_o[4:0] == 5'h01 && avs_readdata_o[6:5] == 2'h0;
   endproperty
   a_lanes_ro: assert property (p_lanes_ro)
      else $error("lane count reads wrong");

   property p_rsv_read;
      @(posedge clk_i) disable iff (!rst_n_i)
      (acc_go && avs_read_i) |=>
         avs_readdata_o[31:8] == 24'h000000;
   endproperty
   a_rsv_read: assert property (p_rsv_read)
      else $error("upper read data bits nonzero");

   property p_ilas_once;
      @(posedge clk_i) disable iff (!rst_n_i)
      ilas_start_o |=> !ilas_start_o;
   endproperty
   a_ilas_once: assert property (p_ilas_once)
      else $error("alignment start longer than one cycle");

   property p_sync_abort;
      @(posedge clk_i) disable iff (!rst_n_i)
      !sync_n_i |=> state == jtl_pkg::JTL_IDLE && !ilas_start_o;
   endproperty
   a_sync_abort: assert property (p_sync_abort)
      else $error("sync request did not abort alignment");
endmodule
`default_nettype wire

// File: logic/jtl_pkg.sv
// constants, field layouts and types for the transmit link config bank
// assumes one 200 mhz clock and a word-addressed register map
package jtl_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_ALIGN_TEST = 12'h574;
   localparam logic [11:0] IDX_LMFC_OFF = 12'h578;
   localparam logic [11:0] IDX_DEV_ID = 12'h580;
   localparam logic [11:0] IDX_BANK_ID = 12'h581;
   localparam logic [11:0] IDX_LANE0_ID = 12'h583;
   localparam logic [11:0] IDX_LANE1_ID = 12'h585;
   localparam logic [11:0] IDX_SCR_LANES = 12'h58b;
   localparam logic [11:0] IDX_OCTETS = 12'h58c;
   localparam int SCR_BIT = 7;
   localparam int DLY_LSB = 4;
   localparam logic [7:0] RST_DEV_ID = 8'h00;
   localparam logic [3:0] RST_BANK_ID = 4'h0;
   localparam logic [4:0] RST_LANE0_ID = 5'h00;
   localparam logic [4:0] RST_LANE1_ID = 5'h02;
   localparam logic RST_SCR_EN = 1'b1;
   localparam logic [4:0] RST_LMFC_OFF = 5'h00;
   localparam logic [3:0] RST_ILAS_DLY = 4'h0;
   localparam logic [2:0] RST_TEST_SEL = 3'h0;
   localparam logic [4:0] LANE_COUNT = 5'h01;
   localparam logic [7:0] OCTETS_M1 = 8'h01;
   // frames per multiframe lies outside this bank; the counter wraps at 32
   localparam logic [4:0] LMFC_LAST = 5'h1f;
   localparam logic [7:0] D21_5_OCTET = 8'hb5;

   typedef enum logic [2:0] {
      JTL_NORMAL = 3'b000,
      JTL_D21_5 = 3'b001,
      JTL_RPAT = 3'b100,
      JTL_JSPAT = 3'b101,
      JTL_JTSPAT = 3'b110
   } jtl_mode_t;

   typedef enum logic [1:0] {
      JTL_IDLE = 2'b00,
      JTL_WAIT = 2'b01,
      JTL_RUN = 2'b10
   } jtl_state_t;

   typedef struct packed {
      logic [7:0] dev_id;
      logic [3:0] bank_id;
      logic [4:0] lane0_id;
      logic [4:0] lane1_id;
      logic scr_en;
      logic [4:0] lmfc_off;
      logic [3:0] ilas_dly;
      logic [2:0] test_sel;
   } jtl_cfg_t;
endpackage
